//--- rtl/load_store_address_gen.sv
// Execute-stage address generation for pc-relative address forming and
// immediate-offset loads and stores. Assumes decode presents one op with
// opValid, and that memory answers each access with memReady / memRdValid.
// Function
// - Address op writes program counter plus signed immediate
// - Address op immediate spans -4095 to +4095 bytes
// - Address op leaves the condition flags untouched
// - Offset mode: access at base plus/minus imm, base unchanged
// - Pre-indexed: access at base plus/minus imm, written back
// - Post-indexed: access at base, then base plus/minus imm written
// - Missing immediate in offset mode uses base directly
// - Unsigned octet and sixteen-bit loads zero-extend to 32 bits
// - Signed kinds sign-extend and are legal only for loads
// - Transfers move one register, or two in the dual form
// - Single-register imm ranges -255..4095 offset, -255..255 indexed
// - Dual imm is a multiple of four within +-1020
// - Failing predicate makes the op have no effect
`timescale 1ns/10ps
module load_store_address_gen #(
	parameter int unsigned DATA_W = ls_addr_pkg::DATA_W
)(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic opValid,
	output logic opReady,
	input wire ls_addr_pkg::op_kind_t opKind,
	input wire ls_addr_pkg::addr_mode_t addrMode,
	input wire ls_addr_pkg::xfer_size_t xferSize,
	input wire ls_addr_pkg::cond_t opCond,
	input wire logic immPresent,
	input wire logic immSubtract,
	input wire logic [ls_addr_pkg::IMM_W-1:0] immMagnitude,
	input wire logic [3:0] flagsNzcv,
	input wire logic [DATA_W-1:0] programCounter,
	input wire logic [ls_addr_pkg::REG_IDX_W-1:0] destReg,
	input wire logic [ls_addr_pkg::REG_IDX_W-1:0] baseRegIdx,
	input wire logic [DATA_W-1:0] baseReg,
	input wire logic [ls_addr_pkg::REG_IDX_W-1:0] transferReg,
	input wire logic [ls_addr_pkg::REG_IDX_W-1:0] secondTransferReg,
	input wire logic [DATA_W-1:0] transferData,
	input wire logic [DATA_W-1:0] secondTransferData,
	output logic memReq,
	output logic memWrite,
	output logic [DATA_W-1:0] memAddr,
	output logic [DATA_W-1:0] memWrData,
	output ls_addr_pkg::xfer_size_t memSize,
	input wire logic memReady,
	input wire logic memRdValid,
	input wire logic [DATA_W-1:0] memRdData,
	output logic regWrEn,
	output logic [ls_addr_pkg::REG_IDX_W-1:0] regWrIdx,
	output logic [DATA_W-1:0] regWrData,
	output logic baseWrEn,
	output logic [ls_addr_pkg::REG_IDX_W-1:0] baseWrIdx,
	output logic [DATA_W-1:0] baseWrData,
	output logic flagsWrEn,
	output logic illegalOp,
	output logic skippedOp
);
	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rstMeta_q, rstSync_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Predicate evaluation; f carries N, Z, C, V from bit 3 down
	function automatic logic condPass(input ls_addr_pkg::cond_t c,
		input logic [3:0] f);
		logic r;
		unique case (c)
			ls_addr_pkg::CC_EQ: r = f[2];
			ls_addr_pkg::CC_NE: r = !f[2];
			ls_addr_pkg::CC_CS: r = f[1];
			ls_addr_pkg::CC_CC: r = !f[1];
			ls_addr_pkg::CC_MI: r = f[3];
			ls_addr_pkg::CC_PL: r = !f[3];
			ls_addr_pkg::CC_VS: r = f[0];
			ls_addr_pkg::CC_VC: r = !f[0];
			ls_addr_pkg::CC_HI: r = f[1] && !f[2];
			ls_addr_pkg::CC_LS: r = !f[1] || f[2];
			ls_addr_pkg::CC_GE: r = (f[3] == f[0]);
			ls_addr_pkg::CC_LT: r = (f[3] != f[0]);
			ls_addr_pkg::CC_GT: r = !f[2] && (f[3] == f[0]);
			ls_addr_pkg::CC_LE: r = f[2] || (f[3] != f[0]);
			default: r = 1'b1;
		endcase
		return r;
	endfunction : condPass
	// Add or subtract magnitude; the carry out is dropped on purpose
	function automatic logic [DATA_W-1:0] offsetAdd(
		input logic [DATA_W-1:0] b, input logic sub,
		input logic [ls_addr_pkg::IMM_W-1:0] m);
		return sub ? DATA_W'(b - DATA_W'(m))
			: DATA_W'(b + DATA_W'(m));
	endfunction : offsetAdd
	// Load data extension by kind
	function automatic logic [DATA_W-1:0] extendLoad(
		input ls_addr_pkg::xfer_size_t s, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		unique case (s)
			ls_addr_pkg::SZ_OCTET: r = DATA_W'(d[7:0]);
			ls_addr_pkg::SZ_SIXTEEN: r = DATA_W'(d[15:0]);
			ls_addr_pkg::SZ_SIGNED_OCTET:
				r = {{(DATA_W-8){d[7]}}, d[7:0]};
			ls_addr_pkg::SZ_SIGNED_SIXTEEN:
				r = {{(DATA_W-16){d[15]}}, d[15:0]};
			default: r = d;
		endcase
		return r;
	endfunction : extendLoad
	// ----------------------------------------------------------------
	// Decode-time checks
	// ----------------------------------------------------------------
	logic [ls_addr_pkg::IMM_W-1:0] immEff;
	logic isDual, rangeOk, kindOk;
	logic [DATA_W-1:0] indexed;
	always_comb
	begin
		// Absent immediate behaves as zero offset
		immEff = immPresent ? immMagnitude : '0;
		isDual = (xferSize == ls_addr_pkg::SZ_DUAL);
		indexed = offsetAdd(baseReg, immSubtract, immEff);
		if (opKind == ls_addr_pkg::OP_ADR)
			rangeOk = (int'(immEff) <= ls_addr_pkg::ADR_IMM_MAX);
		else if (isDual)
			rangeOk = (int'(immEff) <= ls_addr_pkg::DUAL_MAX)
				&& ((immEff[1:0] & ls_addr_pkg::DUAL_ALIGN_MASK) == 2'h0);
		else if (immSubtract)
			rangeOk = (int'(immEff) <= ls_addr_pkg::SINGLE_NEG_MAX);
		else if (addrMode == ls_addr_pkg::MODE_OFFSET)
			rangeOk = (int'(immEff) <= ls_addr_pkg::SINGLE_OFS_MAX);
		else
			rangeOk = (int'(immEff) <= ls_addr_pkg::SINGLE_IDX_MAX);
		// Signed kinds are refused on stores
		kindOk = !(opKind == ls_addr_pkg::OP_STORE
			&& (xferSize == ls_addr_pkg::SZ_SIGNED_OCTET
			|| xferSize == ls_addr_pkg::SZ_SIGNED_SIXTEEN));
	end
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ls_addr_pkg::seq_state_t st;
		logic isLoad, dual, wb;
		ls_addr_pkg::xfer_size_t size;
		logic [DATA_W-1:0] addr, wbVal;
		logic [ls_addr_pkg::REG_IDX_W-1:0] baseIdx, rt, rt2;
		logic [DATA_W-1:0] data2;
		logic req, wr;
		logic [DATA_W-1:0] mAddr, mData;
		logic rwe;
		logic [ls_addr_pkg::REG_IDX_W-1:0] ridx;
		logic [DATA_W-1:0] rdata;
		logic bwe;
		logic [DATA_W-1:0] bdata;
		logic ill, skip;
	} state_t;
	state_t s_q, s_d;
	// Next-state logic; one op in flight, memory back-pressure stalls it
	always_comb
	begin
		s_d = s_q;
		s_d.rwe = 1'b0;
		s_d.bwe = 1'b0;
		s_d.ill = 1'b0;
		s_d.skip = 1'b0;
		unique case (s_q.st)
			ls_addr_pkg::ST_IDLE:
			begin
				if (opValid && opKind != ls_addr_pkg::OP_NONE)
				begin
					if (!condPass(opCond, flagsNzcv))
						s_d.skip = 1'b1;
					else if (!rangeOk || !kindOk)
						s_d.ill = 1'b1;
					else if (opKind == ls_addr_pkg::OP_ADR)
					begin
						s_d.rwe = 1'b1;
						s_d.ridx = destReg;
						s_d.rdata = offsetAdd(programCounter, immSubtract,
							immEff);
					end
					else
					begin
						s_d.isLoad = (opKind == ls_addr_pkg::OP_LOAD);
						s_d.dual = isDual;
						s_d.size = isDual ? ls_addr_pkg::SZ_WORD : xferSize;
						s_d.addr = (addrMode == ls_addr_pkg::MODE_POST)
							? baseReg : indexed;
						s_d.wb = (addrMode != ls_addr_pkg::MODE_OFFSET);
						s_d.wbVal = indexed;
						s_d.baseIdx = baseRegIdx;
						s_d.rt = transferReg;
						s_d.rt2 = secondTransferReg;
						s_d.data2 = secondTransferData;
						s_d.req = 1'b1;
						s_d.wr = (opKind == ls_addr_pkg::OP_STORE);
						s_d.mAddr = s_d.addr;
						s_d.mData = transferData;
						s_d.st = ls_addr_pkg::ST_FIRST;
					end
				end
			end
			ls_addr_pkg::ST_FIRST, ls_addr_pkg::ST_SECOND:
			begin
				if (memReady)
				begin
					s_d.req = 1'b0;
					s_d.st = s_q.isLoad ? ls_addr_pkg::ST_WAIT
						: s_q.st;
					if (!s_q.isLoad)
					begin
						if (s_q.dual && s_q.st == ls_addr_pkg::ST_FIRST)
						begin
							// Second word sits one word above the first
							s_d.req = 1'b1;
							s_d.mAddr = DATA_W'(s_q.addr + ls_addr_pkg::WORD_STEP);
							s_d.mData = s_q.data2;
							s_d.st = ls_addr_pkg::ST_SECOND;
						end
						else
						begin
							s_d.bwe = s_q.wb;
							s_d.bdata = s_q.wbVal;
							s_d.st = ls_addr_pkg::ST_IDLE;
						end
					end
					else
						s_d.dual = s_q.dual && (s_q.st == ls_addr_pkg::ST_FIRST);
				end
			end
			ls_addr_pkg::ST_WAIT:
			begin
				if (memRdValid)
				begin
					s_d.rwe = 1'b1;
					s_d.ridx = (s_q.dual || !s_q.req) && s_q.mAddr != s_q.addr
						? s_q.rt2 : s_q.rt;
					s_d.rdata = extendLoad(s_q.size, memRdData);
					if (s_q.dual)
					begin
						// Fetch the second word of the pair
						s_d.req = 1'b1;
						s_d.mAddr = DATA_W'(s_q.addr + ls_addr_pkg::WORD_STEP);
						s_d.st = ls_addr_pkg::ST_SECOND;
					end
					else
					begin
						s_d.bwe = s_q.wb;
						s_d.bdata = s_q.wbVal;
						s_d.st = ls_addr_pkg::ST_IDLE;
					end
				end
			end
		endcase
	end
	// State register, cleared only by the synchronised reset copy
	always_ff @(posedge clk_sys or negedge rstSync_q)
	begin
		if (!rstSync_q)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign opReady = (s_q.st == ls_addr_pkg::ST_IDLE);
	assign memReq = s_q.req;
	assign memWrite = s_q.wr;
	assign memAddr = s_q.mAddr;
	assign memWrData = s_q.mData;
	assign memSize = s_q.size;
	assign regWrEn = s_q.rwe;
	assign regWrIdx = s_q.ridx;
	assign regWrData = s_q.rdata;
	assign baseWrEn = s_q.bwe;
	assign baseWrIdx = s_q.baseIdx;
	assign baseWrData = s_q.bdata;
	// No op of this block ever updates NZCV
	assign flagsWrEn = 1'b0;
	assign illegalOp = s_q.ill;
	assign skippedOp = s_q.skip;
endmodule : load_store_address_gen

//--- rtl/ls_addr_pkg.sv
// Shared constants and types for the load/store address generator.
// Assumes a 32-bit core with sixteen architectural registers.
package ls_addr_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_IDX_W = 4;
	localparam int unsigned IMM_W = 13;
	// Offset limits per form
	localparam int ADR_IMM_MAX = 4095;
	localparam int SINGLE_OFS_MAX = 4095;
	localparam int SINGLE_NEG_MAX = 255;
	localparam int SINGLE_IDX_MAX = 255;
	localparam int DUAL_MAX = 1020;
	localparam logic [1:0] DUAL_ALIGN_MASK = 2'h3;
	localparam logic [DATA_W-1:0] WORD_STEP = 32'h0000_0004;
	localparam logic [REG_IDX_W-1:0] SP_IDX = 4'hD;
	localparam logic [REG_IDX_W-1:0] PC_IDX = 4'hF;
	localparam int COND_W = 4;

	// Operation kinds
	typedef enum logic [2:0]
	{
		OP_NONE = 3'h0,
		OP_ADR = 3'h1,
		OP_LOAD = 3'h2,
		OP_STORE = 3'h3
	} op_kind_t;

	// Addressing modes
	typedef enum logic [1:0]
	{
		MODE_OFFSET = 2'h0,
		MODE_PRE = 2'h1,
		MODE_POST = 2'h2
	} addr_mode_t;

	// Transfer sizes and extension kinds
	typedef enum logic [2:0]
	{
		SZ_WORD = 3'h0,
		SZ_OCTET = 3'h1,
		SZ_SIXTEEN = 3'h2,
		SZ_SIGNED_OCTET = 3'h3,
		SZ_SIGNED_SIXTEEN = 3'h4,
		SZ_DUAL = 3'h5
	} xfer_size_t;

	// Predicate codes
	typedef enum logic [3:0]
	{
		CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2, CC_CC = 4'h3,
		CC_MI = 4'h4, CC_PL = 4'h5, CC_VS = 4'h6, CC_VC = 4'h7,
		CC_HI = 4'h8, CC_LS = 4'h9, CC_GE = 4'hA, CC_LT = 4'hB,
		CC_GT = 4'hC, CC_LE = 4'hD, CC_AL = 4'hE, CC_NV = 4'hF
	} cond_t;

	// Execute-stage sequencing
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_FIRST = 2'b01,
		ST_SECOND = 2'b10,
		ST_WAIT = 2'b11
	} seq_state_t;
endpackage : ls_addr_pkg

//--- sim/load_store_address_gen_tb.sv
// Self-checking bench for the load/store address generator.
// Assumes the memory responder model and the bound port checker.
`timescale 1ns/10ps
module load_store_address_gen_tb;
	logic clk_sys = 1'b0, arst_n = 1'b0, opValid = 1'b0;
	logic immPresent = 1'b1, immSubtract = 1'b0;
	logic opReady, memReq, memWrite, memReady, memRdValid, regWrEn;
	logic baseWrEn, flagsWrEn, illegalOp, skippedOp;
	ls_addr_pkg::op_kind_t opKind = ls_addr_pkg::OP_NONE;
	ls_addr_pkg::addr_mode_t addrMode = ls_addr_pkg::MODE_OFFSET;
	ls_addr_pkg::xfer_size_t xferSize = ls_addr_pkg::SZ_WORD, memSize;
	ls_addr_pkg::cond_t opCond = ls_addr_pkg::CC_AL;
	logic [12:0] immMagnitude = 13'h0;
	logic [3:0] flagsNzcv = 4'h0, destReg = 4'h0, baseRegIdx = 4'h0;
	logic [3:0] transferReg = 4'h0, secondTransferReg = 4'h0;
	logic [3:0] regWrIdx, baseWrIdx;
	logic [31:0] programCounter = 32'h0, baseReg = 32'h0;
	logic [31:0] transferData = 32'h0, secondTransferData = 32'h0;
	logic [31:0] memAddr, memWrData, memRdData, regWrData, baseWrData;
	integer seed = 32'he18d;
	int error_cnt = 0;
	int checked = 0;
	logic [35:0] regQ[$], baseQ[$];
	logic [67:0] memQ[$];
	logic [1:0] flagQ[$];
	load_store_address_gen DUT (.*);
	ls_mem_model mem (.*);
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// Compare, verdict, reference functions
	// ----------------------------------------
	task automatic chk(string nm, logic [67:0] seen, logic [67:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Even codes test a flag term, odd codes its inverse
	function automatic logic cond_ok(int c, logic [3:0] f);
		logic [7:0] t;
		t = {1'b1, !f[2] && f[3] == f[0], f[3] == f[0], f[1] && !f[2], f[0],
			f[3], f[1], f[2]};
		return t[c / 2] ^ c[0];
	endfunction : cond_ok
	function automatic logic [31:0] ext(int s, logic [31:0] v);
		case (s)
			1: return {24'h0, v[7:0]};
			2: return {16'h0, v[15:0]};
			3: return {{24{v[7]}}, v[7:0]};
			4: return {{16{v[15]}}, v[15:0]};
			default: return v;
		endcase
	endfunction : ext
	// Offer one op, note its expected effects, wait until idle
	task automatic op(int k, int m, int s, int c, logic [12:0] mag,
		logic pres = 1'b1);
		logic [31:0] b, a, nb, ea, v, w;
		logic [12:0] mg;
		logic [3:0] f, dst;
		logic sub, ill, dual;
		int i;
		sub = $random(seed);
		b = $random(seed) & 32'hFFFF_FFFC;
		v = $random(seed);
		w = $random(seed);
		f = $random(seed);
		dst = $random(seed) & 4'h7;
		mg = pres ? mag : 13'h0;
		nb = sub ? b - mg : b + mg;
		ea = m == 2 ? b : nb;
		dual = s == 5;
		ill = k == 1 ? mg > 4095 : dual ? mg > 1020 || mg[1:0] != 2'h0
			: (k == 3 && (s == 3 || s == 4))
			|| mg > ((m == 0 && !sub) ? 4095 : 255);
		opValid <= 1'b1;
		opKind <= ls_addr_pkg::op_kind_t'(k);
		addrMode <= ls_addr_pkg::addr_mode_t'(m);
		xferSize <= ls_addr_pkg::xfer_size_t'(s);
		opCond <= ls_addr_pkg::cond_t'(c);
		{immPresent, immSubtract, immMagnitude} <= {pres, sub, mag};
		{flagsNzcv, destReg, baseRegIdx} <= {f, dst, 4'h9};
		{transferReg, secondTransferReg} <= 8'h12;
		{programCounter, baseReg} <= {b, b};
		{transferData, secondTransferData} <= {v, w};
		i = 0;
		do @(posedge clk_sys); while (opReady !== 1'b1 && ++i < 20);
		if (i >= 20)
		begin
			error_cnt++;
			print_verdict();
		end
		opValid <= 1'b0;
		if (!cond_ok(c, f))
			flagQ.push_back(2'h1);
		else if (ill)
			flagQ.push_back(2'h2);
		else if (k == 1)
			regQ.push_back({dst, nb});
		else
		begin
			for (int n = 0; n <= dual; n++)
			begin
				a = ea + 32'(4 * n);
				// Size code, write flag, address, store data (zero on loads)
				memQ.push_back({3'(dual ? 0 : s), k == 3, a,
					k == 3 ? (n ? w : v) : 32'h0});
				if (k == 2)
					regQ.push_back({4'(n + 1), ext(s, a * 32'h9E37_79B1)});
			end
			if (m != 0)
				baseQ.push_back({4'h9, nb});
		end
		repeat (2) @(posedge clk_sys);
		while ((opReady & !memReq) !== 1'b1 && ++i < 60)
			@(posedge clk_sys);
		if (i >= 60)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask : op
	// ----------------------------------------
	// Output watcher: oldest note against each result
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		logic [67:0] e;
		if (regWrEn === 1'b1)
			chk("reg", {regWrIdx, regWrData}, regQ.size() ? regQ.pop_front() : 'x);
		if (baseWrEn === 1'b1)
			chk("base", {baseWrIdx, baseWrData}, baseQ.size() ? baseQ.pop_front() : 'x);
		if ((illegalOp | skippedOp) === 1'b1)
			chk("flag", {illegalOp, skippedOp}, flagQ.size() ? flagQ.pop_front() : 'x);
		if ((memReq & memReady) === 1'b1)
		begin
			e = memQ.size() ? memQ.pop_front() : 'x;
			chk("mem", {memSize, memWrite, memAddr,
				e[64] ? memWrData : 32'h0}, e);
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int c = 0; c < 15; c++)
			op(1, 0, 0, c, 13'($random(seed)) & 13'h0FFF);
		op(1, 0, 0, 14, 13'h0FFF);
		op(1, 0, 0, 14, 13'h1000);
		// Odd offset from an aligned base gives a branch-exchange target
		op(1, 0, 0, 14, 13'h0801);
		for (int k = 2; k < 4; k++)
			for (int s = 0; s < 6; s++)
				for (int m = 0; m < 3; m++)
					op(k, m, s, 14, 13'($random(seed)) & (s == 5 ? 13'h03FC
						: m == 0 ? 13'h0FFC : 13'h00FC));
		op(3, 0, 1, 14, 13'h0FFF);
		op(2, 1, 0, 14, 13'h0100);
		op(3, 2, 1, 14, 13'h00FF);
		op(2, 1, 5, 14, 13'h03FC);
		op(3, 2, 5, 14, 13'h0400);
		op(2, 0, 5, 14, 13'h03FE);
		op(2, 0, 0, 14, 13'h0ABC, 1'b0);
		op(3, 1, 0, 1, 13'h0010);
		repeat (10) @(posedge clk_sys);
		chk("drain", regQ.size() + baseQ.size() + memQ.size() + flagQ.size(), 0);
		print_verdict();
	end
endmodule : load_store_address_gen_tb

//--- sim/ls_addr_chk_assertions.sv
// Port-level checks for the load/store address generator.
// Assumes one clock domain; bound into every generator instance.
`timescale 1ns/10ps
module ls_addr_chk #(
	parameter int unsigned DATA_W = 32
)(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic opValid,
	input wire logic opReady,
	input wire ls_addr_pkg::op_kind_t opKind,
	input wire ls_addr_pkg::addr_mode_t addrMode,
	input wire ls_addr_pkg::xfer_size_t xferSize,
	input wire ls_addr_pkg::cond_t opCond,
	input wire logic immPresent,
	input wire logic immSubtract,
	input wire logic [ls_addr_pkg::IMM_W-1:0] immMagnitude,
	input wire logic [3:0] flagsNzcv,
	input wire logic [DATA_W-1:0] programCounter,
	input wire logic [DATA_W-1:0] baseReg,
	input wire logic memReq,
	input wire logic memReady,
	input wire logic [DATA_W-1:0] memAddr,
	input wire logic regWrEn,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic flagsWrEn,
	input wire logic illegalOp,
	input wire logic skippedOp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// Helpers: accepted ops and expected sums
	// ----------------------------------------
	logic take, al, adr, ld, one;
	logic [DATA_W-1:0] ofs, nxt, ea, pcs;
	assign take = opValid && opReady && opKind != ls_addr_pkg::OP_NONE;
	assign al = take && opCond == ls_addr_pkg::CC_AL;
	assign adr = al && opKind == ls_addr_pkg::OP_ADR;
	assign ld = al && opKind == ls_addr_pkg::OP_LOAD;
	assign ofs = immPresent ? DATA_W'(immMagnitude) : '0;
	assign nxt = immSubtract ? baseReg - ofs : baseReg + ofs;
	assign ea = addrMode == ls_addr_pkg::MODE_POST ? baseReg : nxt;
	assign pcs = immSubtract ? programCounter - ofs : programCounter + ofs;
	// Legal single load; indexed forms always carry an immediate
	assign one = ld && xferSize != ls_addr_pkg::SZ_DUAL && (immPresent
		? ofs <= ((addrMode == ls_addr_pkg::MODE_OFFSET && !immSubtract)
		? 4095 : 255) : addrMode == ls_addr_pkg::MODE_OFFSET);
	// Refused op leaves no trace on memory or registers
	sequence s_bad;
		##1 illegalOp && !memReq && !regWrEn;
	endsequence
	property p_flags; !flagsWrEn; endproperty
	a_flags: assert property (p_flags)
		else $error("flag write seen");
	property p_adr; adr && ofs <= 4095 |=>
		regWrEn && regWrData == $past(pcs); endproperty
	a_adr: assert property (p_adr)
		else $error("address sum wrong");
	property p_adrRng; adr && ofs > 4095 |-> s_bad; endproperty
	a_adrRng: assert property (p_adrRng)
		else $error("address range not refused");
	property p_skip; take && opCond == ls_addr_pkg::CC_EQ && !flagsNzcv[2]
		|=> skippedOp && !regWrEn && !memReq; endproperty
	a_skip: assert property (p_skip)
		else $error("failed predicate had effect");
	property p_ea; one |=> memReq && memAddr == $past(ea); endproperty
	a_ea: assert property (p_ea)
		else $error("access address wrong");
	property p_hold; memReq && !memReady |=> memReq && $stable(memAddr);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request dropped early");
	property p_sst; al && opKind == ls_addr_pkg::OP_STORE
		&& (xferSize == ls_addr_pkg::SZ_SIGNED_OCTET
		|| xferSize == ls_addr_pkg::SZ_SIGNED_SIXTEEN) |-> s_bad; endproperty
	a_sst: assert property (p_sst)
		else $error("signed store not refused");
	property p_idx; ld && xferSize == ls_addr_pkg::SZ_WORD && immPresent
		&& addrMode != ls_addr_pkg::MODE_OFFSET && immMagnitude > 255
		|-> s_bad; endproperty
	a_idx: assert property (p_idx)
		else $error("indexed range not refused");
	property p_dual; ld && xferSize == ls_addr_pkg::SZ_DUAL && immPresent
		&& immMagnitude[1:0] != 2'h0 |-> s_bad; endproperty
	a_dual: assert property (p_dual)
		else $error("dual alignment not refused");
endmodule : ls_addr_chk
bind load_store_address_gen ls_addr_chk #(.DATA_W(DATA_W)) chk (.*);

//--- sim/ls_mem_model.sv
// Data memory responder: random stalls, read data one cycle after accept.
// Assumes requests hold until memReady is seen high.
`timescale 1ns/10ps
module ls_mem_model (
	input wire logic clk_sys,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	output logic memReady,
	output logic memRdValid,
	output logic [31:0] memRdData
);
	integer seed = 32'he18d;
	initial
	begin
		memReady = 1'b0;
		memRdValid = 1'b0;
		memRdData = 32'h0;
	end
	// Stale read data flips every cycle so it never passes for fresh data
	always @(posedge clk_sys)
	begin
		memRdValid <= 1'b0;
		memRdData <= ~memRdData;
		memReady <= memReq && !memReady && $random(seed) % 2 == 0;
		if (memReq && memReady && !memWrite)
		begin
			memRdValid <= 1'b1;
			memRdData <= memAddr * 32'h9E37_79B1;
		end
	end
endmodule : ls_mem_model
